/* File: rtl/pec_consts.svh */
// Purpose: offsets, field positions, reset values and weights of the pair
// Assumes: byte-style offsets on a 6-bit register port
// Notes:   bit 5 of the address selects the channel
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH
`define PEC_CNT_W       48
`define PEC_ADDR_W      6
`define PEC_CH_BIT      5
`define PEC_OFF_CFG     5'h00
`define PEC_OFF_START   5'h04
`define PEC_OFF_END     5'h08
`define PEC_OFF_CNT_LO  5'h0C
`define PEC_OFF_CNT_HI  5'h10
`define PEC_OFF_STAT    5'h14
`define PEC_OFF_CTRL    5'h18
`define PEC_CFG_SEL_LSB 0
`define PEC_CFG_SEL_MSB 4
`define PEC_CFG_MODE    8
`define PEC_CFG_GATE    9
`define PEC_CTRL_INIT   0
`define PEC_STAT_OVF    0
`define PEC_STAT_WIN    1
`define PEC_RST_SEL     5'h00
`define PEC_RST_PC      32'h0000_0000
`define PEC_W_RATIO0    8'h03
`define PEC_W_RATIO1    8'h04
`define PEC_W_RATIO2    8'h06
`define PEC_W_RATIO3    8'h08
`define PEC_W_RATIO4    8'h0C
`define PEC_W_RATIO5    8'h18
`define PEC_FPU_NIBBLE  4'hF
`define PEC_SYS_MASK    16'hF0FF
`endif

/* File: rtl/pec_pkg.sv */
// Purpose: types shared by the counter pair
// Assumes: constants come from pec_consts.svh
// Notes:   event codes follow enum order
package pec_pkg;
    typedef enum logic [4:0] {
        PEC_EV_ELAPSED, PEC_EV_ICACHE_MISS, PEC_EV_TLB_A, PEC_EV_TLB_B,
        PEC_EV_FETCH_A, PEC_EV_FETCH_B, PEC_EV_ISSUE, PEC_EV_DUAL,
        PEC_EV_FPU, PEC_EV_BRK_A, PEC_EV_BRK_B, PEC_EV_FRZ_I,
        PEC_EV_FRZ_D, PEC_EV_FRZ_BR, PEC_EV_IFILL
    } pec_event_t;
    typedef enum logic {PEC_MODE_CPU, PEC_MODE_RATIO} pec_mode_t;
    typedef struct packed {
        logic [47:0] cnt;
        logic        ovf;
    } pec_chan_st_t;
    typedef struct packed {
        logic [1:0][4:0]  sel;
        logic [1:0]       mode;
        logic [1:0]       gate;
        logic [1:0][31:0] start_pc;
        logic [1:0][31:0] end_pc;
        logic [1:0]       win;
        logic [1:0]       init;
        logic             bt_seen;
        logic [31:0]      rdata;
    } pec_main_st_t;
endpackage

/* File: rtl/pec_chan.sv */
// Purpose: one 48-bit measurement accumulator with sticky overflow
// Assumes: amount and ratio select arrive on the same clock
// Notes:   init clears count and flag; an active init cycle loads the step
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_chan
    import pec_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        init_in,
    input  wire logic        ratio_mode_in,
    input  wire logic [2:0]  ratio_sel_in,
    input  wire logic        active_in,
    input  wire logic [2:0]  amount_in,
    output logic      [47:0] count_out,
    output logic             ovf_out
);
    pec_chan_st_t st_r;
    pec_chan_st_t st_nxt;
    logic [7:0]   weight;
    logic [10:0]  step;
    logic [48:0]  sum;

    always_comb begin
        case (ratio_sel_in)
            3'h0:    weight = `PEC_W_RATIO0;
            3'h1:    weight = `PEC_W_RATIO1;
            3'h2:    weight = `PEC_W_RATIO2;
            3'h3:    weight = `PEC_W_RATIO3;
            3'h4:    weight = `PEC_W_RATIO4;
            default: weight = `PEC_W_RATIO5;
        endcase
        // event amount in cpu mode, amount times ratio weight otherwise; see (RULE14)
        if (ratio_mode_in == PEC_MODE_RATIO) begin
            step = 11'(amount_in * weight); // see (RULE15)
        end else begin
            step = {8'h00, amount_in}; // see (RULE14)
        end
        sum = {1'b0, st_r.cnt} + {38'h0, step}; // see (RULE17)
        st_nxt = st_r;
        if (init_in) begin
            st_nxt.cnt = 48'h0000_0000_0000;
            st_nxt.ovf = 1'b0; // see (RULE21)
        end
        if (active_in) begin
            st_nxt.cnt = init_in ? 48'(step) : sum[47:0];
            if (!init_in && sum[48]) begin
                st_nxt.ovf = 1'b1; // see (RULE18)
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_out = st_r.cnt;
    assign ovf_out   = st_r.ovf;

    cpu_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $past(active_in && !init_in && !ratio_mode_in) && !$past(sum[48])
        |-> st_r.cnt == $past(st_r.cnt) + 48'($past(amount_in)))
        else $error("cpu mode step is not the event amount"); // see (RULE14)
    ratio_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $past(active_in && !init_in && ratio_mode_in && amount_in == 3'h1
        && ratio_sel_in == 3'h5) && !$past(sum[48])
        |-> st_r.cnt == $past(st_r.cnt) + 48'h18)
        else $error("ratio step at top ratio is not 24"); // see (RULE15)
    ovf_sticky_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        st_r.ovf && !init_in |=> st_r.ovf)
        else $error("overflow flag dropped without init"); // see (RULE21)
    ovf_set_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        active_in && !init_in && sum[48] |=> st_r.ovf)
        else $error("wraparound did not set overflow"); // see (RULE18)
endmodule

/* File: rtl/pec_pair.sv */
// Purpose: two-channel performance event counter with register port
// Assumes: core event strobes are synchronous to clk_in (cpu clock)
// Notes:   read data appear only in the cycle after the read strobe
// Contract
// (RULE1) icache miss counts slow and uncached fetches
// (RULE2) icache miss counts speculative overrun fetch misses
// (RULE3) tlb misses count even when overridden
// (RULE4) fetch counters count accepted fetch requests
// (RULE5) dual issue adds one to issue counters
// (RULE6) fetch exception adds one to three
// (RULE7) fpu issue: F opcodes plus fpu system moves
// (RULE8) break matches count even for emulator conditions
// (RULE9) cache freeze includes internal and uncached stalls
// (RULE10) branch freeze adds one per branch; the code adds none for a branch when slot_delayed_in is set
// (RULE11) branch target miss stalls go to fill; the code sends only the second and later stall cycles
// (RULE12) branch freeze observes every branch kind
// (RULE13) counting method chosen per channel
// (RULE14) cpu mode adds one per cycle
// (RULE15) ratio mode adds ratio weight per cycle
// (RULE16) host prefers ratio mode when ratio changes
// (RULE17) each channel holds a 48-bit count
// (RULE18) overflow marks result invalid, reported
// (RULE19) channel gates on start and end pc
// (RULE20) elapsed event counts every window cycle
// (RULE21) sticky overflow cleared with counter by init
// (RULE22) simultaneous events add their combined amount
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_pair
    import pec_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic [5:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rd_data_out,
    input  wire logic        run_in,
    input  wire logic [31:0] pc_in,
    input  wire logic        pc_valid_in,
    input  wire logic [2:0]  ratio_sel_in,
    input  wire logic        fetch_slow_in,
    input  wire logic        overrun_fetch_miss_in,
    input  wire logic        itlb_miss_in,
    input  wire logic        dtlb_miss_in,
    input  wire logic        fetch_acc_a_in,
    input  wire logic        fetch_acc_b_in,
    input  wire logic        issue0_in,
    input  wire logic        issue1_in,
    input  wire logic [15:0] opcode0_in,
    input  wire logic [15:0] opcode1_in,
    input  wire logic        fetch_exc_in,
    input  wire logic [1:0]  fetch_exc_cnt_in,
    input  wire logic        brk_match_a_in,
    input  wire logic        brk_match_b_in,
    input  wire logic        istall_cache_in,
    input  wire logic        istall_internal_in,
    input  wire logic        istall_uncached_in,
    input  wire logic        ostall_cache_in,
    input  wire logic        ostall_internal_in,
    input  wire logic        ostall_uncached_in,
    input  wire logic        branch_exec_in,
    input  wire logic        slot_delayed_in,
    input  wire logic        exc_freeze_in,
    input  wire logic        icache_fill_in,
    input  wire logic        bt_miss_stall_in,
    output logic      [1:0]  ovf_out
);
    localparam int NSYS = 8;
    localparam logic [15:0] SYS_PAT [NSYS] = '{
        16'h405A, 16'h4056, 16'h406A, 16'h4066,
        16'h005A, 16'h4052, 16'h006A, 16'h4062
    };

    pec_main_st_t st_r;
    pec_main_st_t st_nxt;
    logic [2:0]   ev_amt [32];
    logic [1:0]   exc_amt;
    logic         dual;
    logic         fpu0;
    logic         fpu1;
    logic [1:0]   start_hit;
    logic [1:0]   end_hit;
    logic [1:0]   ch_active;
    logic [2:0]   ch_amt [2];
    logic [47:0]  ch_cnt [2];
    logic [1:0]   ch_ovf;
    logic         rd_ch;
    logic [4:0]   off;
    logic [31:0]  rd_val;

    function automatic logic is_fpu(input logic [15:0] op);
        logic hit;
        hit = (op[15:12] == `PEC_FPU_NIBBLE);
        for (int k = 0; k < NSYS; k++) begin
            if ((op & `PEC_SYS_MASK) == SYS_PAT[k]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // event amounts for one cycle; distinct sources add, but issue, fpu, stall and fill sources of one event merge; see (RULE22)
    always_comb begin
        for (int e = 0; e < 32; e++) begin
            ev_amt[e] = 3'h0;
        end
        dual    = issue0_in && issue1_in;
        fpu0    = issue0_in && is_fpu(opcode0_in); // see (RULE7)
        fpu1    = issue1_in && is_fpu(opcode1_in); // see (RULE7)
        // a zero count from the core still adds one; see (RULE6)
        exc_amt = !fetch_exc_in ? 2'h0 :
                  (fetch_exc_cnt_in == 2'h0) ? 2'h1 : fetch_exc_cnt_in;
        ev_amt[PEC_EV_ELAPSED] = 3'h1; // see (RULE20)
        ev_amt[PEC_EV_ICACHE_MISS] = {2'h0, fetch_slow_in} // see (RULE1)
            + {2'h0, overrun_fetch_miss_in}; // see (RULE2)
        ev_amt[PEC_EV_TLB_A]   = {2'h0, itlb_miss_in}; // see (RULE3)
        ev_amt[PEC_EV_TLB_B]   = {2'h0, dtlb_miss_in}; // see (RULE3)
        ev_amt[PEC_EV_FETCH_A] = {2'h0, fetch_acc_a_in}; // see (RULE4)
        ev_amt[PEC_EV_FETCH_B] = {2'h0, fetch_acc_b_in}; // see (RULE4)
        ev_amt[PEC_EV_ISSUE] = {2'h0, issue0_in || issue1_in} // see (RULE5)
            + {1'b0, exc_amt}; // see (RULE6)
        ev_amt[PEC_EV_DUAL] = {2'h0, dual} + {1'b0, exc_amt}; // see (RULE6)
        ev_amt[PEC_EV_FPU]  = {2'h0, fpu0 || fpu1}; // see (RULE5)
        ev_amt[PEC_EV_BRK_A] = {2'h0, brk_match_a_in}; // see (RULE8)
        ev_amt[PEC_EV_BRK_B] = {2'h0, brk_match_b_in}; // see (RULE8)
        ev_amt[PEC_EV_FRZ_I] = {2'h0, istall_cache_in // see (RULE9)
            || istall_internal_in || istall_uncached_in};
        ev_amt[PEC_EV_FRZ_D] = {2'h0, ostall_cache_in // see (RULE9)
            || ostall_internal_in || ostall_uncached_in};
        // any branch kind, one cycle unless the slot runs late
        ev_amt[PEC_EV_FRZ_BR] = // see (RULE10) (RULE12)
            {2'h0, branch_exec_in && !slot_delayed_in}
            + {2'h0, exc_freeze_in};
        // second and later target-miss stall cycles; see (RULE11)
        ev_amt[PEC_EV_IFILL] = {2'h0, icache_fill_in
            || (bt_miss_stall_in && st_r.bt_seen)};
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            assign start_hit[g] = pc_valid_in
                && pc_in == st_r.start_pc[g];
            assign end_hit[g]   = pc_valid_in && pc_in == st_r.end_pc[g];
            // whole run, or from start pc through end pc; see (RULE19)
            assign ch_active[g] = run_in
                && (!st_r.gate[g] || st_r.win[g] || start_hit[g]);
            assign ch_amt[g]    = ev_amt[st_r.sel[g]];
            pec_chan u_chan (
                .clk_in        (clk_in),
                .nrst_in       (nrst_in),
                .init_in       (st_r.init[g]),
                .ratio_mode_in (st_r.mode[g]), // see (RULE13)
                .ratio_sel_in  (ratio_sel_in),
                .active_in     (ch_active[g]),
                .amount_in     (ch_amt[g]),
                .count_out     (ch_cnt[g]),
                .ovf_out       (ch_ovf[g])
            );
        end
    endgenerate

    assign rd_ch = addr_in[`PEC_CH_BIT];
    assign off   = addr_in[4:0];

    always_comb begin
        if (off == `PEC_OFF_CFG) begin
            rd_val = {22'h0, st_r.gate[rd_ch], st_r.mode[rd_ch], 3'h0,
                      st_r.sel[rd_ch]};
        end else if (off == `PEC_OFF_START) begin
            rd_val = st_r.start_pc[rd_ch];
        end else if (off == `PEC_OFF_END) begin
            rd_val = st_r.end_pc[rd_ch];
        end else if (off == `PEC_OFF_CNT_LO) begin
            rd_val = ch_cnt[rd_ch][31:0];
        end else if (off == `PEC_OFF_CNT_HI) begin
            rd_val = {16'h0, ch_cnt[rd_ch][47:32]};
        end else if (off == `PEC_OFF_STAT) begin
            // invalid result reported to the host; see (RULE18)
            rd_val = {30'h0, st_r.win[rd_ch], ch_ovf[rd_ch]};
        end else begin
            rd_val = 32'h0000_0000;
        end
    end

    always_comb begin
        st_nxt         = st_r;
        st_nxt.init    = 2'b00;
        st_nxt.bt_seen = bt_miss_stall_in; // see (RULE11)
        st_nxt.rdata   = rd_in ? rd_val : 32'h0000_0000;
        for (int c = 0; c < 2; c++) begin
            st_nxt.win[c] = st_r.gate[c] && run_in // see (RULE19)
                && (start_hit[c] || (st_r.win[c] && !end_hit[c]));
        end
        if (wr_in) begin
            if (off == `PEC_OFF_CFG) begin
                st_nxt.sel[rd_ch]  =
                    wr_data_in[`PEC_CFG_SEL_MSB:`PEC_CFG_SEL_LSB];
                st_nxt.mode[rd_ch] = wr_data_in[`PEC_CFG_MODE];
                st_nxt.gate[rd_ch] = wr_data_in[`PEC_CFG_GATE];
            end else if (off == `PEC_OFF_START) begin
                st_nxt.start_pc[rd_ch] = wr_data_in;
            end else if (off == `PEC_OFF_END) begin
                st_nxt.end_pc[rd_ch] = wr_data_in;
            end else if (off == `PEC_OFF_CTRL) begin // see (RULE21)
                st_nxt.init[rd_ch] = wr_data_in[`PEC_CTRL_INIT];
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_out = st_r.rdata;
    assign ovf_out     = ch_ovf;

    rd_only_after_a: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        !$past(rd_in) |-> rd_data_out == 32'h0000_0000)
        else $error("read data shown without a read");
    stat_ovf_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_in && off == `PEC_OFF_STAT
        |=> rd_data_out[0] == $past(ovf_out[rd_ch]))
        else $error("status read does not show overflow"); // see (RULE18)
    dual_one_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        dual && !fetch_exc_in |-> ev_amt[PEC_EV_ISSUE] == 3'h1
        && ev_amt[PEC_EV_FPU] <= 3'h1)
        else $error("dual issue did not add exactly one"); // see (RULE5)
    exc_range_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        fetch_exc_in |-> exc_amt >= 2'h1 && exc_amt <= 2'h3)
        else $error("fetch exception amount out of range"); // see (RULE6)
    fpu_nibble_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        issue0_in && opcode0_in[15:12] == 4'hF |-> ev_amt[PEC_EV_FPU] == 3'h1)
        else $error("F opcode not counted as fpu issue"); // see (RULE7)
    branch_one_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        branch_exec_in && !slot_delayed_in && !exc_freeze_in
        |-> ev_amt[PEC_EV_FRZ_BR] == 3'h1)
        else $error("branch freeze not exactly one"); // see (RULE10)
    fill_route_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        bt_miss_stall_in && $past(bt_miss_stall_in)
        |-> ev_amt[PEC_EV_IFILL] == 3'h1)
        else $error("target miss stall not sent to fill"); // see (RULE11)
    win_close_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        st_r.gate[0] && st_r.win[0] && end_hit[0] && !start_hit[0]
        |=> !st_r.win[0])
        else $error("window did not close at end pc"); // see (RULE19)
endmodule

/* File: dv/pec_core_model.sv */
// Purpose: stand-in for the core, caches and break-match unit
// Assumes: events are driven only while en_in is high
// Notes:   strobe bit order is shared with the bench connection list
`timescale 1ns/1ns
module pec_core_model (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        en_in,
    output logic      [21:0] strobe_out,
    output logic      [1:0]  exc_cnt_out,
    output logic      [15:0] opcode0_out,
    output logic      [15:0] opcode1_out,
    output logic      [31:0] pc_out,
    output logic             pc_valid_out,
    output logic             run_out
);
    integer      seed;
    logic [31:0] r;
    logic [15:0] op_tab [6];

    initial begin
        seed = 3733;
        op_tab[0] = 16'hF3AC;
        op_tab[1] = 16'h435A;
        op_tab[2] = 16'h4D66;
        op_tab[3] = 16'h0B6A;
        op_tab[4] = 16'h4A0B;
        op_tab[5] = 16'h6123;
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strobe_out <= 22'h0;
            exc_cnt_out <= 2'h0;
            opcode0_out <= 16'h0;
            opcode1_out <= 16'h0;
            pc_out <= 32'h0000_1000;
            pc_valid_out <= 1'b0;
            run_out <= 1'b0;
        end else if (en_in) begin
            r = $random(seed);
            // fill strobe never shares a cycle with a branch-target stall
            strobe_out <= {r[21], r[20] & ~r[21], r[19:0]};
            exc_cnt_out <= r[23:22];
            opcode0_out <= op_tab[{$random(seed)} % 6];
            opcode1_out <= op_tab[{$random(seed)} % 6];
            pc_out <= pc_out + 32'h2;
            pc_valid_out <= 1'b1;
            run_out <= 1'b1;
        end else begin
            strobe_out <= 22'h0;
            pc_valid_out <= 1'b0;
            run_out <= 1'b0;
        end
    end
endmodule

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the counter pair
// Assumes: core model drives events, bench drives the register port
// Notes:   expectations come from a cycle mirror of both channels
`timescale 1ns/1ns
`include "pec_consts.svh"
module testbench;
    logic        clk_in;
    logic        nrst_in;
    logic [5:0]  addr;
    logic [31:0] wdat;
    logic        wr_s;
    logic        rd_s;
    logic [31:0] rdat;
    logic [2:0]  ratio;
    logic        en;
    logic [21:0] st;
    logic [1:0]  xc;
    logic [15:0] op0;
    logic [15:0] op1;
    logic [31:0] pc;
    logic        pcv;
    logic        run;
    logic [1:0]  ovf;
    logic [47:0] exp_cnt [2];
    logic [4:0]  sel [2];
    logic        mode [2];
    logic        gate [2];
    logic        win [2];
    logic [31:0] spc [2];
    logic [31:0] epc [2];
    logic        bt_prev;
    logic [1:0]  clr;
    integer      seed;
    int          err_count;
    int          compares;

    pec_core_model pec_core_model_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .en_in(en), .strobe_out(st),
        .exc_cnt_out(xc), .opcode0_out(op0), .opcode1_out(op1),
        .pc_out(pc), .pc_valid_out(pcv), .run_out(run));
    pec_pair pec_pair_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdat),
        .run_in(run), .pc_in(pc), .pc_valid_in(pcv), .ratio_sel_in(ratio),
        .fetch_slow_in(st[0]), .overrun_fetch_miss_in(st[1]),
        .itlb_miss_in(st[2]), .dtlb_miss_in(st[3]),
        .fetch_acc_a_in(st[4]), .fetch_acc_b_in(st[5]),
        .issue0_in(st[6]), .issue1_in(st[7]), .opcode0_in(op0),
        .opcode1_in(op1), .fetch_exc_in(st[8]), .fetch_exc_cnt_in(xc),
        .brk_match_a_in(st[9]), .brk_match_b_in(st[10]),
        .istall_cache_in(st[11]), .istall_internal_in(st[12]),
        .istall_uncached_in(st[13]), .ostall_cache_in(st[14]),
        .ostall_internal_in(st[15]), .ostall_uncached_in(st[16]),
        .branch_exec_in(st[17]), .slot_delayed_in(st[18]),
        .exc_freeze_in(st[19]), .icache_fill_in(st[20]),
        .bt_miss_stall_in(st[21]), .ovf_out(ovf));

    always #10 clk_in = ~clk_in;
    // ratio keeps changing, so ratio mode is the meaningful one
    always @(posedge clk_in) ratio <= 3'($random(seed));

    function automatic logic is_fpu(input logic [15:0] op);
        return op[15:12] == 4'hF || (op & 16'hF0FF) inside {16'h405A,
            16'h4056, 16'h406A, 16'h4066, 16'h005A, 16'h4052, 16'h006A,
            16'h4062};
    endfunction

    function automatic int weight(input logic [2:0] r);
        case (r)
            3'h0: return 3;
            3'h1: return 4;
            3'h2: return 6;
            3'h3: return 8;
            3'h4: return 12;
            default: return 24;
        endcase
    endfunction

    function automatic int amt(input logic [4:0] e);
        int xa;
        xa = st[8] ? ((xc == 2'h0) ? 1 : int'(xc)) : 0;
        case (e)
            5'h00: return 1;
            5'h01: return int'(st[0]) + int'(st[1]);
            5'h02: return int'(st[2]);
            5'h03: return int'(st[3]);
            5'h04: return int'(st[4]);
            5'h05: return int'(st[5]);
            5'h06: return int'(st[6] | st[7]) + xa;
            5'h07: return int'(st[6] & st[7]) + xa;
            5'h08: return int'((st[6] && is_fpu(op0)) ||
                (st[7] && is_fpu(op1)));
            5'h09: return int'(st[9]);
            5'h0A: return int'(st[10]);
            5'h0B: return int'(|st[13:11]);
            5'h0C: return int'(|st[16:14]);
            5'h0D: return int'(st[17] & ~st[18])
                + int'(st[19]);
            5'h0E: return int'(st[20])
                + int'(st[21] & bt_prev);
            default: return 0;
        endcase
    endfunction

    function automatic logic [47:0] exp_step(input int c);
        return 48'(amt(sel[c])
            * (mode[c] ? weight(ratio) : 1));
    endfunction

    // cycle mirror; an init write clears the count one edge later
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int c = 0; c < 2; c++) begin
                exp_cnt[c] <= 48'h0;
                win[c] <= 1'b0;
            end
            clr <= 2'b00;
            bt_prev <= 1'b0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (run && (!gate[c] || win[c] || (pcv && pc == spc[c])))
                    exp_cnt[c] <= (clr[c] ? 48'h0 : exp_cnt[c]) + exp_step(c);
                else if (clr[c])
                    exp_cnt[c] <= 48'h0;
                win[c] <= run && (win[c] || (pcv && pc == spc[c]))
                    && !(pcv && pc == epc[c]);
                clr[c] <= wr_s && addr == {c[0], `PEC_OFF_CTRL} && wdat[0];
            end
            bt_prev <= st[21];
        end
    end

    task automatic chk(input string nm, input logic [47:0] ex,
                       input logic [47:0] got);
        compares++;
        if (got !== ex) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        @(posedge clk_in);
        d = rdat;
    endtask

    task automatic rd48(input int c, output logic [47:0] v);
        logic [31:0] lo;
        logic [31:0] hi;
        rd({c[0], `PEC_OFF_CNT_LO}, lo);
        rd({c[0], `PEC_OFF_CNT_HI}, hi);
        v = {hi[15:0], lo};
    endtask

    task automatic cfg_ch(input int c, input logic [4:0] e, input logic m);
        sel[c] = e;
        mode[c] = m;
        gate[c] = 1'($random(seed));
        spc[c] = pc + 32'h2 + ({$random(seed)} % 32'h10) * 32'h2;
        epc[c] = spc[c] + 32'h2 + ({$random(seed)} % 32'h10) * 32'h2;
        wr({c[0], `PEC_OFF_START}, spc[c]);
        wr({c[0], `PEC_OFF_END}, epc[c]);
        wr({c[0], `PEC_OFF_CFG}, {22'h0, gate[c], m, 3'h0, e});
    endtask

    task automatic finish_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        finish_test;
    end

    initial begin
        logic [47:0] v;
        logic [31:0] d;
        logic [4:0]  ev;
        seed = 3733;
        clk_in = 1'b0;
        nrst_in = 1'b0;
        {addr, wdat, wr_s, rd_s, en} = '0;
        for (int c = 0; c < 2; c++) begin
            {sel[c], mode[c], gate[c]} = '0;
            {spc[c], epc[c]} = '0;
        end
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        for (int a = 0; a < 64; a += 4) begin
            if (a % 32 != 24) begin
                rd(6'(a), d);
                chk("reset read", 48'h0, {16'h0, d});
            end
        end
        wr(6'h0C, 32'hFFFF_FFFF);
        rd48(0, v);
        chk("count after write", 48'h0, v);
        for (int it = 0; it < 30; it++) begin
            ev = 5'(it % 15);
            cfg_ch(0, ev, it >= 15);
            cfg_ch(1, 5'h0E - ev, it < 15);
            en <= 1'b1;
            repeat (40) @(posedge clk_in);
            en <= 1'b0;
            repeat (3) @(posedge clk_in);
            for (int c = 0; c < 2; c++) begin
                rd48(c, v);
                chk("event count", exp_cnt[c], v);
                rd({c[0], `PEC_OFF_STAT}, d);
                chk("overflow status", 48'h0, {47'h0, d[0]});
                wr({c[0], `PEC_OFF_CTRL}, 32'h1);
            end
        end
        for (int c = 0; c < 2; c++) begin
            rd48(c, v);
            chk("count after init", 48'h0, v);
        end
        chk("overflow flags", 48'h0, {46'h0, ovf});
        finish_test;
    end
endmodule
